// ---- bench/fbc_cmd_checker.sv ----
// Purpose: port-level assertions on the fieldbus command interface
// Assumes: two-cycle frame-to-action latency
// Notes:   frames during safety shutdown are not checked
`timescale 1ns/1ps
module fbc_cmd_checker (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rstn,
   // frames, configuration and burner state
   input wire logic       frame_valid,
   input wire logic [7:0] frame_addr,
   input wire logic       frame_has_output,
   input wire logic [7:0] master_command_byte,
   input wire logic [7:0] station_address_param,
   input wire logic [7:0] bus_function_config_param,
   input wire logic [7:0] aux_output_function_param,
   input wire logic       burner_starting,
   input wire logic       burner_operating,
   // outputs
   input wire logic       heat_request,
   input wire logic       auxiliary_output,
   input wire logic       cooling_air_output,
   input wire logic       remote_unlock,
   input wire logic       safety_shutdown,
   input wire logic       protocol_modbus,
   input wire logic       bus_active,
   input wire logic       address_off,
   input wire logic       address_valid,
   input wire logic [7:0] active_address
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire take = frame_valid && address_valid && frame_addr == active_address && !safety_shutdown;

   a_frame_bus_up: assert property (take |-> ##2 bus_active)
      else $error("bus not active after frame");
   a_heat_from_cmd: assert property (take && frame_has_output |-> ##2 heat_request == $past(master_command_byte[0], 2))
      else $error("heat does not follow command");
   a_aux_follows: assert property (take && frame_has_output && aux_output_function_param == 8'h08
      |-> ##2 auxiliary_output == $past(master_command_byte[3], 2))
      else $error("aux does not follow command");
   a_cool_busy_off: assert property ((burner_starting || burner_operating) [*2] |-> !cooling_air_output)
      else $error("cooling on while burner busy");
   a_unlock_single: assert property (remote_unlock |=> !remote_unlock)
      else $error("unlock pulse too long");
   a_shut_needs_cfg: assert property ($rose(safety_shutdown) |-> bus_function_config_param[4])
      else $error("shutdown without valve on bus");
   a_proto_held: assert property (!$fell(protocol_modbus))
      else $error("protocol changed in operation");
   a_addr_off_shown: assert property ($past(rstn) && $stable(station_address_param)
      |-> address_off == (station_address_param == 8'h00))
      else $error("address off flag wrong");

   c_frame: cover property (take ##2 heat_request);
   c_unlock: cover property (remote_unlock);
   c_shutdown: cover property ($rose(safety_shutdown));
endmodule

bind fbc_command_interface fbc_cmd_checker u_chk (.*);

// ---- bench/fbc_master_model.sv ----
// Purpose: fieldbus master model issuing one-cycle command frames
// Assumes: frames are already decoded, one frame_valid pulse per frame
// Notes:   idle data lines toggle so stale values are never trusted
`timescale 1ns/1ps
module fbc_master_model (
   // clock
   input  wire logic sys_clk,
   // decoded frame
   output logic       frame_valid,
   output logic       frame_has_output,
   output logic [7:0] frame_addr,
   output logic [7:0] master_command_byte
);
   logic       req = 1'b0;
   logic       req_has = 1'b0;
   logic [7:0] req_addr = 8'h00;
   logic [7:0] req_byte = 8'h00;
   initial begin
      frame_valid = 1'b0;
      frame_has_output = 1'b0;
      frame_addr = 8'h00;
      master_command_byte = 8'h00;
   end
   // one frame per call; the bench spaces calls to keep the loss timer fed
   task automatic send(input logic [7:0] a, input logic h, input logic [7:0] b);
      @(posedge sys_clk) begin
         req_addr <= a;
         req_has <= h;
         req_byte <= b;
         req <= 1'b1;
      end
      @(posedge sys_clk) req <= 1'b0;
   endtask
   always @(posedge sys_clk) begin
      frame_valid <= req;
      frame_addr <= req ? req_addr : ~frame_addr;
      frame_has_output <= req ? req_has : ~frame_has_output;
      master_command_byte <= req ? req_byte : ~master_command_byte;
   end
endmodule

// ---- bench/tb_fbc_command_interface.sv ----
// Purpose: self-checking bench for the fieldbus command interface
// Assumes: shortened minute 200, unlock 10..100, watchdog 50 cycles
// Notes:   frames are fed every few cycles to keep the bus alive
`timescale 1ns/1ps
module tb_fbc_command_interface;
   logic        sys_clk = 0, rstn = 0, addr_from_tool = 0, enhanced_unlock = 0, protocol_switch = 0;
   logic        hw_heat_request = 1, burner_starting = 0, burner_operating = 0, in_start_release_state = 1;
   logic [7:0]  station_address_param = 8'h00, stage_output_config_param = 8'h01;
   logic [7:0]  bus_function_config_param = 8'h0f, aux_output_function_param = 8'h08;
   logic [35:0] watchdog_cycles = 36'd50;
   logic        frame_valid, frame_has_output, heat_request, stage_two_output, remote_unlock, auxiliary_output;
   logic        cooling_air_output, main_burner_start, start_release, safety_shutdown, protocol_modbus;
   logic        bus_active, bus_indicator, address_off, address_valid, address_change_error;
   logic [7:0]  frame_addr, master_command_byte, active_address;
   logic [7:0]  av [4] = '{8'h63, 8'h64, 8'h7e, 8'h7f};
   int          failures = 0, checks_done = 0, unlocks = 0;
   logic        flash_seen;

   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (remote_unlock === 1'b1) unlocks <= unlocks + 1;

   fbc_command_interface #(.MINUTE_CYCLES(36'd200), .UNLOCK_MIN_CYCLES(36'd10),
      .UNLOCK_MAX_CYCLES(36'd100), .FLASH_CYCLES(36'd8)) DUT (.*);
   fbc_master_model u_master (.*);

   task automatic wt(input int n); repeat (n) @(posedge sys_clk); #1; endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic frame(input logic [7:0] b); u_master.send(8'h05, 1'b1, b); wt(3); endtask
   task automatic restart;
      @(posedge sys_clk) rstn <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      wt(8);
   endtask
   task automatic print_verdict;
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      restart();
      chk(address_off, 1);
      chk(protocol_modbus, 0);
      frame(8'h00);
      chk(bus_active, 0);
      chk(heat_request, 1);
      @(posedge sys_clk) station_address_param <= 8'h05;
      wt(3);
      chk(address_change_error, 1);
      chk(active_address, 8'h00);
      @(posedge sys_clk) enhanced_unlock <= 1'b1;
      @(posedge sys_clk) enhanced_unlock <= 1'b0;
      wt(4);
      chk(active_address, 8'h05);
      chk(address_change_error, 0);
      $display("test address edit done");
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) begin station_address_param <= av[i]; addr_from_tool <= i[1]; end
         restart();
         chk(address_valid, {7'h00, ~i[0]});
      end
      @(posedge sys_clk) begin station_address_param <= 8'h05; addr_from_tool <= 1'b0; end
      restart();
      $display("test address range done");
      frame(8'h80);
      chk(heat_request, 0);
      chk(bus_active, 1);
      flash_seen = bus_indicator;
      wt(8);
      chk(bus_indicator, {7'h00, ~flash_seen});
      u_master.send(8'h06, 1'b1, 8'h01);
      u_master.send(8'h05, 1'b0, 8'h01);
      wt(3);
      chk(heat_request, 0);
      for (int i = 0; i < 7; i++) if (i != 2) begin
         frame(8'h01 << i);
         chk({1'b0, start_release, main_burner_start, cooling_air_output, auxiliary_output, 1'b0,
              stage_two_output, heat_request}, (8'h01 << i) & 8'h7b);
      end
      @(posedge sys_clk) begin burner_operating <= 1'b1; aux_output_function_param <= 8'h00; end
      frame(8'h18);
      chk({cooling_air_output, auxiliary_output}, 8'h00);
      @(posedge sys_clk) begin burner_operating <= 1'b0; burner_starting <= 1'b1; in_start_release_state <= 1'b0; end
      frame(8'h50);
      chk({start_release, cooling_air_output}, 8'h00);
      @(posedge sys_clk) begin burner_starting <= 1'b0; in_start_release_state <= 1'b1; end
      @(posedge sys_clk) aux_output_function_param <= 8'h08;
      $display("test command bits done");
      for (int i = 0; i < 5; i++) frame(8'h04);
      frame(8'h00);
      wt(2);
      chk(unlocks[7:0], 8'h01);
      frame(8'h04);
      frame(8'h00);
      for (int i = 0; i < 40; i++) frame(8'h04);
      frame(8'h00);
      wt(2);
      chk(unlocks[7:0], 8'h01);
      $display("test unlock done");
      @(posedge sys_clk) hw_heat_request <= 1'b0;
      frame(8'h01);
      wt(100);
      chk(heat_request, 1);
      wt(200);
      chk({bus_active, heat_request}, 8'h00);
      $display("test bus loss done");
      @(posedge sys_clk) bus_function_config_param <= 8'h1f;
      frame(8'h01);
      wt(40);
      chk(safety_shutdown, 0);
      wt(20);
      chk(safety_shutdown, 1);
      @(posedge sys_clk) enhanced_unlock <= 1'b1;
      @(posedge sys_clk) enhanced_unlock <= 1'b0;
      wt(3);
      chk(safety_shutdown, 0);
      $display("test shutdown done");
      @(posedge sys_clk) protocol_switch <= 1'b1;
      restart();
      chk(protocol_modbus, 1);
      @(posedge sys_clk) protocol_switch <= 1'b0;
      frame(8'h01);
      wt(150);
      chk({protocol_modbus, safety_shutdown}, 8'h02);
      wt(70);
      chk(safety_shutdown, 1);
      $display("test modbus loss done");
      print_verdict();
   end

   // about 1150 cycles expected
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      print_verdict();
   end
endmodule

// ---- rtl/fbc_command_interface.v ----
// Purpose: fieldbus slave command interface of a gas burner control unit
// Assumes: frame decoding done upstream; one frame_valid pulse per good frame
// Notes:   bus loss times are parameters so a simulation can shorten them
//
// Behaviour
// - accept station address 1..99 locally, up to 126 from the tool.
// - no configured address shows OFF and keeps the device off the bus.
// - a new address takes effect only after restart or enhanced unlock.
// - an altered station address raises an address-change error flag.
// - without bus connection heat request comes from the hardwired input.
// - with bus, heat request comes from bus command; indicator flashes.
// - after bus disconnection, revert to hardwired input after one minute.
// - protocol switch OFF selects Profibus, ON selects Modbus.
// - protocol switch is read at power-up only, later changes ignored.
// - bus loss with second valve on bus shuts down, else fallback later.
// - Profibus cyclic data gap beyond master watchdog counts as bus loss.
// - command bit 0 high is a heat request.
// - command bit 1 drives stage two output per two configuration values.
// - command bit 2 held 0.5 s to 5 s is a remote unlock.
// - aux function 8 keeps aux output on while command bit 3 high.
// - command bit 4 drives cooling valve only when burner idle.
// - command bit 5 switches pilot to main burner, if configured.
// - command bit 6 releases the start wait state, if configured.
// - status-only data modules carry no commands; none accepted.
`timescale 1ns/1ps
`include "fbc_consts.vh"

module fbc_command_interface #(
   parameter [35:0] MINUTE_CYCLES     = `FBC_BUS_LOSS_S * `FBC_CLK_HZ,
   // clock divided first so the 36-bit product cannot wrap
   parameter [35:0] UNLOCK_MIN_CYCLES = `FBC_UNLOCK_MIN_MS * (`FBC_CLK_HZ / `FBC_MS_PER_S),
   parameter [35:0] UNLOCK_MAX_CYCLES = `FBC_UNLOCK_MAX_MS * (`FBC_CLK_HZ / `FBC_MS_PER_S),
   parameter [35:0] FLASH_CYCLES      = `FBC_FLASH_MS * (`FBC_CLK_HZ / `FBC_MS_PER_S)
) (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rstn,
   // received frames
   input  wire        frame_valid,
   input  wire [7:0]  frame_addr,
   input  wire        frame_has_output,
   input  wire [7:0]  master_command_byte,
   // profibus watchdog period set by the master, in clock cycles
   input  wire [35:0] watchdog_cycles,
   // station address configuration
   input  wire [7:0]  station_address_param,
   input  wire        addr_from_tool,
   input  wire        enhanced_unlock,
   // configuration parameters
   input  wire [7:0]  stage_output_config_param,
   input  wire [7:0]  bus_function_config_param,
   input  wire [7:0]  aux_output_function_param,
   // pins
   input  wire        protocol_switch,
   input  wire        hw_heat_request,
   // burner sequence state
   input  wire        burner_starting,
   input  wire        burner_operating,
   input  wire        in_start_release_state,
   // burner actions
   output reg         heat_request,
   output reg         stage_two_output,
   output reg         remote_unlock,
   output reg         auxiliary_output,
   output reg         cooling_air_output,
   output reg         main_burner_start,
   output reg         start_release,
   output reg         safety_shutdown,
   // bus and address status
   output reg         protocol_modbus,
   output reg         bus_active,
   output reg         bus_indicator,
   output reg         address_off,
   output reg         address_valid,
   output reg [7:0]   active_address,
   output reg         address_change_error
);

   // supervision states
   localparam [3:0] ST_IDLE   = 4'b0001;
   localparam [3:0] ST_ACTIVE = 4'b0010;
   localparam [3:0] ST_LOST   = 4'b0100;
   localparam [3:0] ST_SHUT   = 4'b1000;

   reg [3:0]  state;
   reg [3:0]  next_state;
   reg        hw_heat;
   reg        proto_taken;
   reg        addr_load;
   reg [7:0]  cmd;
   reg [35:0] gap_cnt;
   reg [35:0] lost_cnt;
   reg [35:0] unlock_cnt;
   reg [35:0] flash_cnt;
   reg        unlock_prev;

   wire [7:0] addr_max;
   wire       param_ok;
   wire       frame_ours;
   wire       loss_limit_hit;
   wire [35:0] loss_limit;
   wire       use_bus;
   wire       proto_level;
   wire       proto_settled;
   wire       heat_level;
   wire       heat_settled;

   assign addr_max   = addr_from_tool ? `FBC_ADDR_MAX_TOOL : `FBC_ADDR_MAX_LOCAL;
   assign param_ok   = (station_address_param >= `FBC_ADDR_MIN) && (station_address_param <= addr_max);
   assign frame_ours = frame_valid && address_valid && (frame_addr == active_address);
   // modbus needs a query each minute, profibus uses the master watchdog
   assign loss_limit = protocol_modbus ? MINUTE_CYCLES : watchdog_cycles;
   assign loss_limit_hit = (gap_cnt >= loss_limit);
   assign use_bus    = (state == ST_ACTIVE) || (state == ST_LOST);

   // pin synchronisers; a change counts once the second and third stages agree
   fbc_pin_sync #(
      .STAGES  (`FBC_SYNC_STAGES)
   ) u_proto_sync (
      .sys_clk (sys_clk),
      .pin     (protocol_switch),
      .level   (proto_level),
      .settled (proto_settled)
   );

   fbc_pin_sync #(
      .STAGES  (`FBC_SYNC_STAGES)
   ) u_heat_sync (
      .sys_clk (sys_clk),
      .pin     (hw_heat_request),
      .level   (heat_level),
      .settled (heat_settled)
   );

   // hardwired heat input; a half-settled sample keeps the old value
   always @(posedge sys_clk) begin
      if (!rstn) begin
         hw_heat <= 1'b0;
      end else if (heat_settled) begin
         hw_heat <= heat_level;
      end
   end

   // protocol taken once after power-up, later switch changes ignored
   always @(posedge sys_clk) begin
      if (!rstn) begin
         proto_taken     <= 1'b0;
         protocol_modbus <= `FBC_PROTO_PROFIBUS;
      end else if (!proto_taken && proto_settled) begin
         proto_taken     <= 1'b1;
         protocol_modbus <= proto_level ? `FBC_PROTO_MODBUS : `FBC_PROTO_PROFIBUS;
      end
   end

   // station address: loaded once after restart or on enhanced unlock
   always @(posedge sys_clk) begin
      if (!rstn) begin
         addr_load            <= 1'b1;
         address_valid        <= 1'b0;
         active_address       <= `FBC_ADDR_NONE;
         address_off          <= 1'b1;
         address_change_error <= 1'b0;
      end else begin
         addr_load   <= 1'b0;
         address_off <= (station_address_param == `FBC_ADDR_NONE);
         if (addr_load || enhanced_unlock) begin
            address_valid        <= param_ok;
            active_address       <= param_ok ? station_address_param : `FBC_ADDR_NONE;
            address_change_error <= 1'b0;
         end else if (station_address_param != active_address) begin
            // held until the new address is taken into use
            address_change_error <= 1'b1;
         end
      end
   end

   // command byte latch; status-only modules leave it untouched
   always @(posedge sys_clk) begin
      if (!rstn) begin
         cmd <= 8'h00;
      end else if (frame_ours && frame_has_output && (state != ST_SHUT)) begin
         // tested before the bus check so the frame that opens the link is kept
         cmd <= {1'b0, master_command_byte[6:0]};
      end else if (!use_bus) begin
         cmd <= 8'h00;
      end
   end

   // gap since the last frame addressed to us; saturates
   always @(posedge sys_clk) begin
      if (!rstn) begin
         gap_cnt <= 36'h0;
      end else if (frame_ours) begin
         gap_cnt <= 36'h0;
      end else if (!loss_limit_hit) begin
         gap_cnt <= gap_cnt + 36'h1;
      end
   end

   // bus supervision
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (frame_ours) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!address_valid) begin
               next_state = ST_IDLE;
            end else if (loss_limit_hit && !frame_ours) begin
               if (bus_function_config_param[`FBC_CFG_V2_BUS]) begin
                  next_state = ST_SHUT;
               end else begin
                  next_state = ST_LOST;
               end
            end
         end
         ST_LOST: begin
            if (frame_ours) begin
               next_state = ST_ACTIVE;
            end else if (lost_cnt >= MINUTE_CYCLES) begin
               next_state = ST_IDLE;
            end
         end
         ST_SHUT: begin
            // cleared only by restart or enhanced unlock
            if (enhanced_unlock) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         state    <= ST_IDLE;
         lost_cnt <= 36'h0;
      end else begin
         state <= next_state;
         if (state == ST_LOST) begin
            lost_cnt <= lost_cnt + 36'h1;
         end else begin
            lost_cnt <= 36'h0;
         end
      end
   end

   // remote unlock: pulse on release of a bit held within the window
   always @(posedge sys_clk) begin
      if (!rstn) begin
         unlock_cnt    <= 36'h0;
         unlock_prev   <= 1'b0;
         remote_unlock <= 1'b0;
      end else begin
         unlock_prev   <= cmd[`FBC_CMD_UNLOCK];
         remote_unlock <= 1'b0;
         if (cmd[`FBC_CMD_UNLOCK]) begin
            if (unlock_cnt <= UNLOCK_MAX_CYCLES) begin
               unlock_cnt <= unlock_cnt + 36'h1;
            end
         end else begin
            unlock_cnt <= 36'h0;
            if (unlock_prev && (unlock_cnt >= UNLOCK_MIN_CYCLES) && (unlock_cnt <= UNLOCK_MAX_CYCLES)) begin
               remote_unlock <= 1'b1;
            end
         end
      end
   end

   // bus indicator flashes while bus control is active
   always @(posedge sys_clk) begin
      if (!rstn) begin
         flash_cnt     <= 36'h0;
         bus_indicator <= 1'b0;
         bus_active    <= 1'b0;
      end else begin
         bus_active <= use_bus;
         if (!use_bus) begin
            flash_cnt     <= 36'h0;
            bus_indicator <= 1'b0;
         end else if (flash_cnt >= FLASH_CYCLES - 36'h1) begin
            flash_cnt     <= 36'h0;
            bus_indicator <= ~bus_indicator;
         end else begin
            flash_cnt <= flash_cnt + 36'h1;
         end
      end
   end

   // burner actions; all registered
   always @(posedge sys_clk) begin
      if (!rstn) begin
         heat_request       <= 1'b0;
         stage_two_output   <= 1'b0;
         auxiliary_output   <= 1'b0;
         cooling_air_output <= 1'b0;
         main_burner_start  <= 1'b0;
         start_release      <= 1'b0;
         safety_shutdown    <= 1'b0;
      end else begin
         // hardwired input when off the bus, bus command otherwise
         heat_request <= use_bus ? cmd[`FBC_CMD_HEAT] : hw_heat;
         stage_two_output <= cmd[`FBC_CMD_STAGE2] && (stage_output_config_param != 8'h00)
                             && bus_function_config_param[`FBC_CFG_STAGE_EN];
         auxiliary_output <= cmd[`FBC_CMD_AUX] && (aux_output_function_param == `FBC_AUX_FN_BUS);
         cooling_air_output <= cmd[`FBC_CMD_COOL] && bus_function_config_param[`FBC_CFG_COOL_EN]
                               && !burner_starting && !burner_operating;
         main_burner_start <= cmd[`FBC_CMD_MAIN] && bus_function_config_param[`FBC_CFG_MAIN_EN];
         start_release <= cmd[`FBC_CMD_RELEASE] && in_start_release_state
                          && bus_function_config_param[`FBC_CFG_RELEASE_EN];
         safety_shutdown <= (next_state == ST_SHUT);
      end
   end

endmodule

// pin synchroniser; settled is high while the last two stages agree
module fbc_pin_sync #(
   parameter STAGES = 3
) (
   // clock
   input  wire sys_clk,
   // asynchronous pin
   input  wire pin,
   // synchronised view
   output wire level,
   output wire settled
);

   // no reset: the chain keeps tracking the pin while rstn is low,
   // so the first sample after release already reflects the pin
   reg [STAGES-1:0] stages;

   always @(posedge sys_clk) begin
      stages <= {stages[STAGES-2:0], pin};
   end

   assign level   = stages[STAGES-1];
   assign settled = (stages[STAGES-2] == stages[STAGES-1]);

endmodule

// ---- rtl/fbc_consts.vh ----
// Purpose: shared constants of the fieldbus burner command interface
// Assumes: 250 MHz system clock
// Notes:   timing figures kept in their own unit, cycle counts derived
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH

// clock rate
`define FBC_CLK_HZ          36'd250000000
// pin synchroniser depth
`define FBC_SYNC_STAGES     3
// timing figures
`define FBC_BUS_LOSS_S      36'd60
`define FBC_UNLOCK_MIN_MS   36'd500
`define FBC_UNLOCK_MAX_MS   36'd5000
`define FBC_FLASH_MS        36'd500
`define FBC_MS_PER_S        36'd1000

// command byte bit positions
`define FBC_CMD_HEAT        0
`define FBC_CMD_STAGE2      1
`define FBC_CMD_UNLOCK      2
`define FBC_CMD_AUX         3
`define FBC_CMD_COOL        4
`define FBC_CMD_MAIN        5
`define FBC_CMD_RELEASE     6

// bus function configuration fields
`define FBC_CFG_STAGE_EN    0
`define FBC_CFG_MAIN_EN     1
`define FBC_CFG_RELEASE_EN  2
`define FBC_CFG_COOL_EN     3
`define FBC_CFG_V2_BUS      4

// station address limits
`define FBC_ADDR_NONE       8'h00
`define FBC_ADDR_MIN        8'h01
`define FBC_ADDR_MAX_LOCAL  8'h63
`define FBC_ADDR_MAX_TOOL   8'h7e

// auxiliary output function selecting bus control
`define FBC_AUX_FN_BUS      8'h08

// protocol encoding of the captured switch
`define FBC_PROTO_PROFIBUS  1'b0
`define FBC_PROTO_MODBUS    1'b1

`endif
